//--- hw/piwc_io_window_config.sv
// I/O window timing, sizing and address registers for one card socket
`include "piwc_defines.svh"
`default_nettype none

module piwc_io_window_config #(
   parameter logic       SOCKET_ID   = 1'b0,
   parameter logic [3:0] NARROW_STD  = `PIWC_ISA_NARROW_STD,
   parameter logic [3:0] NARROW_FAST = `PIWC_ISA_NARROW_FAST,
   parameter logic [3:0] WIDE_STD    = `PIWC_ISA_WIDE_STD,
   parameter logic [3:0] WIDE_EXTRA  = `PIWC_ISA_WIDE_EXTRA
) (
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // memory-mapped register access, offset inside socket space
   input  wire logic        mem_req,
   input  wire logic        mem_wr,
   input  wire logic [11:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata,
   // indexed compatibility register access
   input  wire logic        idx_req,
   input  wire logic        idx_wr,
   input  wire logic [7:0]  idx_index,
   input  wire logic [7:0]  idx_wdata,
   output logic             idx_ack,
   output logic [7:0]       idx_rdata,
   // window enables from the address window enable register
   input  wire logic        io_window0_enable,
   input  wire logic        io_window1_enable,
   // host I/O cycle lookup
   input  wire logic        io_req,
   input  wire logic [15:0] io_addr,
   input  wire logic        card_iois16,
   output logic             io_done,
   output logic             io_claim,
   output logic             io_window,
   output logic             io_wide,
   output logic [3:0]       io_isa_cycles
);

   if (NARROW_FAST == 4'h0 || NARROW_STD == 4'h0 || WIDE_STD == 4'h0 ||
       5'(WIDE_STD) + 5'(WIDE_EXTRA) > 5'h0F) begin : g_bad_len
      $error("piwc: cycle length parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // register storage and decode

   logic [7:0]         ctrl;
   logic [15:0]        win_start [2];
   logic [15:0]        win_end   [2];
   piwc_pkg::piwc_sel_t mem_sel;
   piwc_pkg::piwc_sel_t idx_sel;
   piwc_pkg::piwc_sel_t wr_sel;
   logic [7:0]         wr_data;

   function automatic piwc_pkg::piwc_sel_t decode(input logic [5:0] idx);
      piwc_pkg::piwc_sel_t s;
      case (idx)
         `PIWC_IDX_CTRL:        s = piwc_pkg::PIWC_SEL_CTRL;
         `PIWC_IDX_W0_START_LO: s = piwc_pkg::PIWC_SEL_S0_LO;
         `PIWC_IDX_W0_START_HI: s = piwc_pkg::PIWC_SEL_S0_HI;
         `PIWC_IDX_W0_END_LO:   s = piwc_pkg::PIWC_SEL_E0_LO;
         `PIWC_IDX_W0_END_HI:   s = piwc_pkg::PIWC_SEL_E0_HI;
         `PIWC_IDX_W1_START_LO: s = piwc_pkg::PIWC_SEL_S1_LO;
         `PIWC_IDX_W1_START_HI: s = piwc_pkg::PIWC_SEL_S1_HI;
         `PIWC_IDX_W1_END_LO:   s = piwc_pkg::PIWC_SEL_E1_LO;
         `PIWC_IDX_W1_END_HI:   s = piwc_pkg::PIWC_SEL_E1_HI;
         default:               s = piwc_pkg::PIWC_SEL_NONE;
      endcase
      return s;
   endfunction

   function automatic logic [7:0] read_reg(input piwc_pkg::piwc_sel_t s,
                                           input logic [7:0]  c,
                                           input logic [15:0] s0,
                                           input logic [15:0] e0,
                                           input logic [15:0] s1,
                                           input logic [15:0] e1);
      logic [7:0] d;
      case (s)
         piwc_pkg::PIWC_SEL_CTRL:  d = c;
         piwc_pkg::PIWC_SEL_S0_LO: d = s0[7:0];
         piwc_pkg::PIWC_SEL_S0_HI: d = s0[15:8];
         piwc_pkg::PIWC_SEL_E0_LO: d = e0[7:0];
         piwc_pkg::PIWC_SEL_E0_HI: d = e0[15:8];
         piwc_pkg::PIWC_SEL_S1_LO: d = s1[7:0];
         piwc_pkg::PIWC_SEL_S1_HI: d = s1[15:8];
         piwc_pkg::PIWC_SEL_E1_LO: d = e1[7:0];
         piwc_pkg::PIWC_SEL_E1_HI: d = e1[15:8];
         default:                  d = 8'h00;
      endcase
      return d;
   endfunction

   // memory decode: block 800h..83Fh of the socket space
   always_comb begin
      if (mem_addr[11:6] == `PIWC_MEM_BLOCK) begin
         mem_sel = decode(mem_addr[5:0]);
      end else begin
         mem_sel = piwc_pkg::PIWC_SEL_NONE;
      end
   end

   // index decode: only this socket's 40h-wide slot answers
   always_comb begin
      if (idx_index[7:6] == {1'b0, SOCKET_ID}) begin
         idx_sel = decode(idx_index[5:0]);
      end else begin
         idx_sel = piwc_pkg::PIWC_SEL_NONE;
      end
   end

   // memory port wins when both ports write in the same cycle
   always_comb begin
      wr_sel  = piwc_pkg::PIWC_SEL_NONE;
      wr_data = 8'h00;
      if (mem_req && mem_wr && mem_sel != piwc_pkg::PIWC_SEL_NONE) begin
         wr_sel  = mem_sel;
         wr_data = mem_wdata;
      end else if (idx_req && idx_wr &&
                   idx_sel != piwc_pkg::PIWC_SEL_NONE) begin
         wr_sel  = idx_sel;
         wr_data = idx_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl <= `PIWC_RST_CTRL;
      end else if (clk_en && wr_sel == piwc_pkg::PIWC_SEL_CTRL) begin
         ctrl <= wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         win_start[0] <= `PIWC_RST_ADDR;
         win_start[1] <= `PIWC_RST_ADDR;
      end else if (clk_en) begin
         case (wr_sel)
            piwc_pkg::PIWC_SEL_S0_LO: win_start[0][7:0]  <= wr_data;
            piwc_pkg::PIWC_SEL_S0_HI: win_start[0][15:8] <= wr_data;
            piwc_pkg::PIWC_SEL_S1_LO: win_start[1][7:0]  <= wr_data;
            piwc_pkg::PIWC_SEL_S1_HI: win_start[1][15:8] <= wr_data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         win_end[0] <= `PIWC_RST_ADDR;
         win_end[1] <= `PIWC_RST_ADDR;
      end else if (clk_en) begin
         case (wr_sel)
            piwc_pkg::PIWC_SEL_E0_LO: win_end[0][7:0]  <= wr_data;
            piwc_pkg::PIWC_SEL_E0_HI: win_end[0][15:8] <= wr_data;
            piwc_pkg::PIWC_SEL_E1_LO: win_end[1][7:0]  <= wr_data;
            piwc_pkg::PIWC_SEL_E1_HI: win_end[1][15:8] <= wr_data;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read answers, one cycle after the request; old value on
   // a read that meets a write

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mem_ack   <= 1'b0;
         mem_rdata <= 8'h00;
      end else if (clk_en) begin
         mem_ack   <= mem_req && mem_sel != piwc_pkg::PIWC_SEL_NONE;
         mem_rdata <= read_reg(mem_sel, ctrl, win_start[0], win_end[0],
                               win_start[1], win_end[1]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         idx_ack   <= 1'b0;
         idx_rdata <= 8'h00;
      end else if (clk_en) begin
         idx_ack   <= idx_req && idx_sel != piwc_pkg::PIWC_SEL_NONE;
         idx_rdata <= read_reg(idx_sel, ctrl, win_start[0], win_end[0],
                               win_start[1], win_end[1]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-window hit, width and cycle length

   logic [1:0]              win_en;
   logic [1:0]              hit;
   piwc_pkg::piwc_width_t   win_width [2];
   logic [3:0]              win_cycles [2];

   assign win_en = {io_window1_enable, io_window0_enable};

   for (genvar w = 0; w < 2; w++) begin : g_win
      localparam int B = w * `PIWC_WIN_FIELD_STRIDE;
      // enable gates the range compare
      assign hit[w] = win_en[w] && io_addr >= win_start[w] &&
                      io_addr <= win_end[w];
      // auto-size overrides the size bit
      assign win_width[w] = ctrl[B + `PIWC_BIT_CARD_SIZED] ?
                            piwc_pkg::piwc_width_t'(card_iois16) :
                            piwc_pkg::piwc_width_t'(
                               ctrl[B + `PIWC_BIT_WIDTH_SELECT]);
      // wait bit only on wide cycles, fast bit only on narrow ones
      assign win_cycles[w] =
         (win_width[w] == piwc_pkg::PIWC_W16) ?
            (ctrl[B + `PIWC_BIT_WIDE_WAIT] ?
               4'(WIDE_STD + WIDE_EXTRA) : WIDE_STD) :
            (ctrl[B + `PIWC_BIT_NARROW_FAST] ?
               NARROW_FAST : NARROW_STD);
   end

   // window 0 wins where both ranges overlap
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         io_done       <= 1'b0;
         io_claim      <= 1'b0;
         io_window     <= 1'b0;
         io_wide       <= 1'b0;
         io_isa_cycles <= 4'h0;
      end else if (clk_en) begin
         io_done <= io_req;
         if (io_req && hit[0]) begin
            io_claim      <= 1'b1;
            io_window     <= 1'b0;
            io_wide       <= win_width[0];
            io_isa_cycles <= win_cycles[0];
         end else if (io_req && hit[1]) begin
            io_claim      <= 1'b1;
            io_window     <= 1'b1;
            io_wide       <= win_width[1];
            io_isa_cycles <= win_cycles[1];
         end else begin
            io_claim      <= 1'b0;
            io_window     <= 1'b0;
            io_wide       <= 1'b0;
            io_isa_cycles <= 4'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic take1;
   logic take0;
   assign take1 = clk_en && io_req && !hit[0] && hit[1];
   assign take0 = clk_en && io_req && hit[0];

   default clocking piwc_cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   AST_W1_WIDE_WAIT: assert property (
      take1 && win_width[1] == piwc_pkg::PIWC_W16 && ctrl[7]
      |=> io_claim && io_window && io_wide &&
          io_isa_cycles == 4'(WIDE_STD + WIDE_EXTRA))
      else $error("window 1 wide cycle missing its extra wait");
   AST_W1_NARROW_FAST: assert property (
      take1 && win_width[1] == piwc_pkg::PIWC_W8
      |=> io_isa_cycles == ($past(ctrl[6]) ? NARROW_FAST : NARROW_STD))
      else $error("window 1 narrow cycle length wrong");
   AST_W1_CARD_SIZED: assert property (
      take1 && ctrl[5] |=> io_wide == $past(card_iois16))
      else $error("window 1 width not taken from the card");
   AST_W1_WIDTH_SEL: assert property (
      take1 && !ctrl[5] |=> io_wide == $past(ctrl[4]))
      else $error("window 1 width not taken from the size bit");

   AST_W0_WIDE_WAIT: assert property (
      take0 && win_width[0] == piwc_pkg::PIWC_W16
      |=> io_isa_cycles ==
          ($past(ctrl[3]) ? 4'(WIDE_STD + WIDE_EXTRA) : WIDE_STD))
      else $error("window 0 wide cycle length wrong");
   AST_W0_NARROW_FAST: assert property (
      take0 && win_width[0] == piwc_pkg::PIWC_W8 && ctrl[2]
      |=> !io_window && !io_wide && io_isa_cycles == NARROW_FAST)
      else $error("window 0 fast narrow cycle length wrong");
   AST_W0_CARD_SIZED: assert property (
      take0 && ctrl[1] |=> io_wide == $past(card_iois16))
      else $error("window 0 width not taken from the card");
   AST_W0_WIDTH_SEL: assert property (
      take0 && !ctrl[1] |=> io_wide == $past(ctrl[0]))
      else $error("window 0 width not taken from the size bit");

   AST_START_LO_WRITE: assert property (
      clk_en && idx_req && idx_wr && !(mem_req && mem_wr) &&
      idx_index == {1'b0, SOCKET_ID, `PIWC_IDX_W1_START_LO}
      |=> win_start[1][7:0] == $past(idx_wdata))
      else $error("window 1 start low byte not written");
   AST_START_HI_WRITE: assert property (
      clk_en && mem_req && mem_wr &&
      mem_addr == {`PIWC_MEM_BLOCK, `PIWC_IDX_W0_START_HI}
      |=> win_start[0][15:8] == $past(mem_wdata))
      else $error("window 0 start high byte not written");
   AST_END_RESET: assert property (disable iff (1'b0)
      sys_rst |=> win_end[0] == 16'h0000 && win_end[1] == 16'h0000)
      else $error("end address not cleared by reset");
   AST_END_HI_WRITE: assert property (
      clk_en && mem_req && mem_wr &&
      mem_addr == {`PIWC_MEM_BLOCK, `PIWC_IDX_W1_END_HI}
      |=> win_end[1][15:8] == $past(mem_wdata))
      else $error("window 1 end high byte not written");
   AST_IDX_CTRL_READ: assert property (
      clk_en && idx_req && !idx_wr &&
      idx_index == {1'b0, SOCKET_ID, `PIWC_IDX_CTRL}
      |=> idx_ack && idx_rdata == $past(ctrl))
      else $error("indexed control read wrong");
   AST_MEM_CTRL_READ: assert property (
      clk_en && mem_req && !mem_wr &&
      mem_addr == {`PIWC_MEM_BLOCK, `PIWC_IDX_CTRL}
      |=> mem_ack && mem_rdata == $past(ctrl))
      else $error("memory control read wrong");
   AST_NO_CLAIM_DISABLED: assert property (
      clk_en && io_req && !io_window0_enable && !io_window1_enable
      |=> io_done && !io_claim)
      else $error("cycle claimed with both windows disabled");
   AST_RANGE_HIT: assert property (
      clk_en && io_req && io_window0_enable &&
      io_addr >= win_start[0] && io_addr <= win_end[0]
      |=> io_claim && !io_window)
      else $error("in-range window 0 cycle not claimed");

   COV_W0_CLAIM: cover property (take0 ##1 io_claim);
   COV_W1_WIDE_WAIT: cover property (take1 && win_width[1] && ctrl[7]);
   COV_CARD_SIZED: cover property (take0 && ctrl[1] && card_iois16);
   COV_BOTH_WRITE: cover property (mem_req && mem_wr && idx_req && idx_wr);

endmodule
`default_nettype wire

//--- hw/piwc_defines.svh
// register offsets, field positions, reset values and cycle counts
`ifndef PIWC_DEFINES_SVH
`define PIWC_DEFINES_SVH

// register indices inside one socket
`define PIWC_IDX_CTRL        6'h07
`define PIWC_IDX_W0_START_LO 6'h08
`define PIWC_IDX_W0_START_HI 6'h09
`define PIWC_IDX_W0_END_LO   6'h0A
`define PIWC_IDX_W0_END_HI   6'h0B
`define PIWC_IDX_W1_START_LO 6'h0C
`define PIWC_IDX_W1_START_HI 6'h0D
`define PIWC_IDX_W1_END_LO   6'h0E
`define PIWC_IDX_W1_END_HI   6'h0F

// memory space: socket base plus this block, plus the index
`define PIWC_MEM_BLOCK       6'h20
// second socket sits this far above the first in the index space
`define PIWC_SOCKET_STRIDE   8'h40

// control register fields, per window at a stride of four bits
`define PIWC_WIN_FIELD_STRIDE 4
`define PIWC_BIT_WIDTH_SELECT 0
`define PIWC_BIT_CARD_SIZED   1
`define PIWC_BIT_NARROW_FAST  2
`define PIWC_BIT_WIDE_WAIT    3

// reset values
`define PIWC_RST_CTRL        8'h00
`define PIWC_RST_ADDR        16'h0000

// card cycle lengths in ISA-equivalent cycles
`define PIWC_ISA_NARROW_STD  4'h6
`define PIWC_ISA_NARROW_FAST 4'h3
`define PIWC_ISA_WIDE_STD    4'h3
`define PIWC_ISA_WIDE_EXTRA  4'h1

`endif

//--- hw/piwc_pkg.sv
// types shared by the I/O window configuration block
`default_nettype none
package piwc_pkg;

   // data width of a card I/O cycle
   typedef enum logic {
      PIWC_W8  = 1'b0,
      PIWC_W16 = 1'b1
   } piwc_width_t;

   // decoded register selection
   typedef enum logic [3:0] {
      PIWC_SEL_NONE  = 4'h0,
      PIWC_SEL_CTRL  = 4'h1,
      PIWC_SEL_S0_LO = 4'h2,
      PIWC_SEL_S0_HI = 4'h3,
      PIWC_SEL_E0_LO = 4'h4,
      PIWC_SEL_E0_HI = 4'h5,
      PIWC_SEL_S1_LO = 4'h6,
      PIWC_SEL_S1_HI = 4'h7,
      PIWC_SEL_E1_LO = 4'h8,
      PIWC_SEL_E1_HI = 4'h9
   } piwc_sel_t;

endpackage
`default_nettype wire

//--- testbench/piwc_card_model.sv
// behavioural 16-bit card: answers the width request for each addressed port
`default_nettype none

module piwc_card_model (
   // host lookup seen at the socket
   input  wire logic        io_req,
   input  wire logic [15:0] io_addr,
   // card width indication, high means a 16-bit port
   output logic             card_iois16
);
   timeunit 1ns;
   timeprecision 1ns;

   // upper half of each 256-byte page decodes as 16-bit ports; the line is
   // pulled back to deasserted whenever the card is not addressed
   assign card_iois16 = io_req & io_addr[7];

endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the I/O window configuration block
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [1:0]  en;
      logic [15:0] addr;
      logic [7:0]  res;
   } piwc_tb_row_t;

   logic        core_clk          = 1'b0;
   logic        sys_rst           = 1'b1;
   logic        clk_en            = 1'b1;
   logic        mem_req           = 1'b0;
   logic        mem_wr            = 1'b0;
   logic [11:0] mem_addr          = 12'h000;
   logic [7:0]  mem_wdata         = 8'h00;
   logic        idx_req           = 1'b0;
   logic        idx_wr            = 1'b0;
   logic [7:0]  idx_index         = 8'h00;
   logic [7:0]  idx_wdata         = 8'h00;
   logic        io_window0_enable = 1'b0;
   logic        io_window1_enable = 1'b0;
   logic        io_req            = 1'b0;
   logic [15:0] io_addr           = 16'h0000;
   logic        card_iois16;
   logic        mem_ack;
   logic [7:0]  mem_rdata;
   logic        idx_ack;
   logic [7:0]  idx_rdata;
   logic        io_done;
   logic        io_claim;
   logic        io_window;
   logic        io_wide;
   logic [3:0]  io_isa_cycles;
   int          mismatches        = 0;
   int          cmp_count         = 0;
   int          cycles            = 0;

   // window 0 at 0100h..01FFh, window 1 at 0200h..02FFh
   logic [7:0] wv [9] = '{8'hA5, 8'h00, 8'h01, 8'hFF, 8'h01,
                          8'h00, 8'h02, 8'hFF, 8'h02};

   // res: done, claim, window, wide, four bits of cycle length
   piwc_tb_row_t rows [22] = '{
      '{8'h00, 2'h3, 16'h0100, 8'hC6}, '{8'h01, 2'h3, 16'h0100, 8'hD3},
      '{8'h09, 2'h3, 16'h0100, 8'hD4}, '{8'h08, 2'h3, 16'h0100, 8'hC6},
      '{8'h04, 2'h3, 16'h0100, 8'hC3}, '{8'h05, 2'h3, 16'h0100, 8'hD3},
      '{8'h02, 2'h3, 16'h0180, 8'hD3}, '{8'h03, 2'h3, 16'h0100, 8'hC6},
      '{8'h10, 2'h3, 16'h0200, 8'hF3}, '{8'h90, 2'h3, 16'h0200, 8'hF4},
      '{8'h80, 2'h3, 16'h0200, 8'hE6}, '{8'h40, 2'h3, 16'h0200, 8'hE3},
      '{8'h50, 2'h3, 16'h0200, 8'hF3}, '{8'h20, 2'h3, 16'h0280, 8'hF3},
      '{8'h30, 2'h3, 16'h0200, 8'hE6}, '{8'h00, 2'h3, 16'h00FF, 8'h80},
      '{8'h00, 2'h3, 16'h01FF, 8'hC6}, '{8'h00, 2'h3, 16'h0300, 8'h80},
      '{8'h00, 2'h2, 16'h0100, 8'h80}, '{8'h00, 2'h1, 16'h0200, 8'h80},
      '{8'h00, 2'h1, 16'h0100, 8'hC6}, '{8'h00, 2'h0, 16'h0100, 8'h80}};

   piwc_io_window_config DUT (
      .core_clk          (core_clk),
      .sys_rst           (sys_rst),
      .clk_en            (clk_en),
      .mem_req           (mem_req),
      .mem_wr            (mem_wr),
      .mem_addr          (mem_addr),
      .mem_wdata         (mem_wdata),
      .mem_ack           (mem_ack),
      .mem_rdata         (mem_rdata),
      .idx_req           (idx_req),
      .idx_wr            (idx_wr),
      .idx_index         (idx_index),
      .idx_wdata         (idx_wdata),
      .idx_ack           (idx_ack),
      .idx_rdata         (idx_rdata),
      .io_window0_enable (io_window0_enable),
      .io_window1_enable (io_window1_enable),
      .io_req            (io_req),
      .io_addr           (io_addr),
      .card_iois16       (card_iois16),
      .io_done           (io_done),
      .io_claim          (io_claim),
      .io_window         (io_window),
      .io_wide           (io_wide),
      .io_isa_cycles     (io_isa_cycles)
   );

   piwc_card_model card (
      .io_req      (io_req),
      .io_addr     (io_addr),
      .card_iois16 (card_iois16)
   );

   always #25 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   // checking and bus tasks

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] pat(input int i);
      pat = {i[3:0], ~i[3:0]};
   endfunction

   // one register access; exp is {ack, read data}, data ignored on writes
   task automatic reg_acc(input logic use_idx, input logic wr,
                          input logic [11:0] a, input logic [7:0] wd,
                          input logic [8:0] exp);
      logic [8:0] got;
      @(negedge core_clk);
      if (use_idx) begin
         idx_req   = 1'b1;
         idx_wr    = wr;
         idx_index = a[7:0];
         idx_wdata = wd;
      end else begin
         mem_req   = 1'b1;
         mem_wr    = wr;
         mem_addr  = a;
         mem_wdata = wd;
      end
      @(negedge core_clk);
      mem_req = 1'b0;
      idx_req = 1'b0;
      got = use_idx ? {idx_ack, idx_rdata} : {mem_ack, mem_rdata};
      if (wr) begin
         got[7:0] = exp[7:0];
      end
      chk({7'h00, got}, {7'h00, exp});
   endtask

   task automatic io_look(input logic [15:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      io_req  = 1'b1;
      io_addr = a;
      @(negedge core_clk);
      io_req = 1'b0;
      chk({8'h00, io_done, io_claim, io_window, io_wide, io_isa_cycles},
          {8'h00, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence

   initial begin
      piwc_tb_row_t r;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      for (int i = 7; i < 16; i++) begin
         reg_acc(1'b0, 1'b0, {6'h20, i[5:0]}, 8'h00, 9'h100);
      end
      for (int i = 7; i < 16; i++) begin
         reg_acc(1'b1, 1'b1, {4'h0, i[7:0]}, pat(i), 9'h100);
         reg_acc(1'b0, 1'b0, {6'h20, i[5:0]}, 8'h00, {1'b1, pat(i)});
      end
      for (int i = 7; i < 16; i++) begin
         reg_acc(1'b0, 1'b1, {6'h20, i[5:0]}, wv[i-7], 9'h100);
         reg_acc(1'b1, 1'b0, 12'(i), 8'h00, {1'b1, wv[i-7]});
      end
      // neighbours' addresses and the other socket's slot are not answered
      reg_acc(1'b0, 1'b0, 12'h806, 8'h00, 9'h000);
      reg_acc(1'b0, 1'b1, 12'h840, 8'h55, 9'h000);
      reg_acc(1'b1, 1'b1, 12'h047, 8'h55, 9'h000);
      reg_acc(1'b1, 1'b0, 12'h007, 8'h00, 9'h1A5);
      for (int k = 0; k < 22; k++) begin
         r = rows[k];
         reg_acc(1'b0, 1'b1, 12'h807, r.ctrl, 9'h100);
         io_window0_enable = r.en[0];
         io_window1_enable = r.en[1];
         io_look(r.addr, r.res);
      end
      // overlapping windows: window 0 takes the shared range
      io_window0_enable = 1'b1;
      io_window1_enable = 1'b1;
      reg_acc(1'b0, 1'b1, 12'h80D, 8'h01, 9'h100);
      io_look(16'h0150, 8'hC6);
      io_look(16'h0200, 8'hE6);
      // requests while the clock enable is low are not taken
      clk_en = 1'b0;
      reg_acc(1'b0, 1'b1, 12'h807, 8'hFF, 9'h000);
      clk_en = 1'b1;
      reg_acc(1'b0, 1'b0, 12'h807, 8'h00, 9'h100);
      // both ports write one register in one cycle: memory port wins
      @(negedge core_clk);
      mem_req   = 1'b1;
      mem_wr    = 1'b1;
      mem_addr  = 12'h80C;
      mem_wdata = 8'h33;
      idx_req   = 1'b1;
      idx_wr    = 1'b1;
      idx_index = 8'h0C;
      idx_wdata = 8'hCC;
      @(negedge core_clk);
      mem_req = 1'b0;
      idx_req = 1'b0;
      chk({14'h0000, mem_ack, idx_ack}, 16'h0003);
      reg_acc(1'b1, 1'b0, 12'h00C, 8'h00, 9'h133);
      // reset in mid-run clears what was programmed
      @(negedge core_clk);
      sys_rst = 1'b1;
      @(negedge core_clk);
      sys_rst = 1'b0;
      reg_acc(1'b0, 1'b0, 12'h80A, 8'h00, 9'h100);
      reg_acc(1'b1, 1'b0, 12'h00D, 8'h00, 9'h100);
      io_look(16'h0150, 8'h80);
      report_and_stop();
   end

endmodule
`default_nettype wire
